// ### ntfc_pkg.sv
// Package: offsets, field positions, reset values and carriers for the function command block
package ntfc_pkg;
  // Configuration dword indices (byte offset / 4)
  localparam logic [9:0] ID_DW = 10'h000;
  localparam logic [9:0] CMD_DW = 10'h001;
  // Identification defaults, arbitrary neutral values
  localparam logic [15:0] VENDOR_CODE_DEF = 16'h1234;
  localparam logic [15:0] DEVICE_CODE_DEF = 16'h5678;
  // Command field positions
  localparam int IO_EN_BIT = 0;
  localparam int MEM_EN_BIT = 1;
  localparam int BM_EN_BIT = 2;
  localparam int PERR_RESP_BIT = 6;
  localparam int SERR_EN_BIT = 8;
  localparam int INTX_DIS_BIT = 10;
  // Writable command bits, all others read zero
  localparam logic [15:0] CMD_WR_MASK = 16'h0547;
  localparam logic [15:0] CMD_RST = 16'h0000;
  // Status field position
  localparam int MPE_BIT = 8;
  localparam int INTS_BIT = 3;
  localparam int CAPL_BIT = 4;
  localparam logic [15:0] STS_RST = 16'h0000;

  // Configuration request from the link
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] dw;
    logic [3:0] be;
    logic [31:0] data;
  } ntfc_cfg_req_s;

  // Decoded command enables
  typedef struct packed {
    logic io_space_enable;
    logic memory_space_enable;
    logic bus_master_enable;
    logic parity_error_response;
    logic system_error_enable;
    logic legacy_interrupt_disable;
  } ntfc_cmd_s;
endpackage : ntfc_pkg

// ### ntfc_gate.sv
// Traffic gating from the command enables
`timescale 1ns/1ps
module ntfc_gate (
  // Enables
  input wire ntfc_pkg::ntfc_cmd_s cmd,
  // Inbound decode
  input wire logic rx_io_hit,
  input wire logic rx_mem_hit,
  output logic rx_unsupported,
  // Outbound requests
  input wire logic ip_req_in,
  input wire logic msi_req_in,
  input wire logic other_req_in,
  output logic ip_req_out,
  output logic msi_req_out,
  output logic other_req_out,
  // Errors and interrupts
  input wire logic err_detect,
  input wire logic dev_ctl_err_en,
  output logic err_report,
  input wire logic intx_req,
  output logic intx_out
);
  // Disabled decode spaces answer as Unsupported Request
  assign rx_unsupported = (rx_io_hit & ~cmd.io_space_enable)
    | (rx_mem_hit & ~cmd.memory_space_enable);
  // Only inter-partition requests and MSIs wait on mastering
  assign ip_req_out = ip_req_in & cmd.bus_master_enable;
  assign msi_req_out = msi_req_in & cmd.bus_master_enable;
  assign other_req_out = other_req_in;
  // Either enable path lets fatal and non-fatal reports out
  assign err_report = err_detect & (cmd.system_error_enable | dev_ctl_err_en);
  assign intx_out = intx_req & ~cmd.legacy_interrupt_disable;
endmodule : ntfc_gate

// ### ntfc_top.sv
// Configuration header start: identification, command and parity status of the function
// Behaviour
// - Vendor code is a read-only 16-bit word at offset zero.
// - Device code is a read-only 16-bit word at offset two.
// - With I/O enable clear, I/O-space TLPs are Unsupported Requests.
// - With memory enable clear, memory-space TLPs are Unsupported Requests.
// - With bus master enable clear, no inter-partition requests go out.
// - With bus master enable clear, MSIs are suppressed.
// - Other requests and completions pass regardless of bus master enable.
// - Poisoned TLPs are logged as master parity errors only with parity response set.
// - Fatal and non-fatal errors are reported if system error or device-control enables allow.
// - Legacy interrupt disable negates INTx; the resolved interrupt state still follows the pending request.
// - Command bits 3,4,5,7,9 and 15:11 read zero and ignore writes.
// - Writable command bits reset to zero.
// - Master parity error status sets on poisoned completion received or poisoned request sent.
`timescale 1ns/1ps
module ntfc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Configuration access
  input wire ntfc_pkg::ntfc_cfg_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Inbound decode
  input wire logic rx_io_hit,
  input wire logic rx_mem_hit,
  output logic rx_unsupported,
  // Outbound requests
  input wire logic ip_req_in,
  input wire logic msi_req_in,
  input wire logic other_req_in,
  output logic ip_req_out,
  output logic msi_req_out,
  output logic other_req_out,
  // Poison events
  input wire logic rx_poison_cpl,
  input wire logic tx_poison_req,
  // Errors and interrupts
  input wire logic err_detect,
  input wire logic dev_ctl_err_en,
  output logic err_report,
  input wire logic intx_req,
  output logic intx_out,
  output logic intx_status
);
  logic [15:0] cmd_reg, cmd_next;
  logic [15:0] sts_reg, sts_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  ntfc_pkg::ntfc_cmd_s cmd;
  logic wr_cmd;
  logic [15:0] wmask;
  logic [15:0] w1c;
  logic mpe_set;

  // Named view of the command register, one driver for the whole struct
  assign cmd = '{
    io_space_enable: cmd_reg[ntfc_pkg::IO_EN_BIT],
    memory_space_enable: cmd_reg[ntfc_pkg::MEM_EN_BIT],
    bus_master_enable: cmd_reg[ntfc_pkg::BM_EN_BIT],
    parity_error_response: cmd_reg[ntfc_pkg::PERR_RESP_BIT],
    system_error_enable: cmd_reg[ntfc_pkg::SERR_EN_BIT],
    legacy_interrupt_disable: cmd_reg[ntfc_pkg::INTX_DIS_BIT]
  };

  assign wr_cmd = cfg_req.valid & cfg_req.write & (cfg_req.dw == ntfc_pkg::CMD_DW);
  // Byte enables select which command and status bytes a write touches
  assign wmask = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
  assign w1c = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}} & cfg_req.data[31:16];
  assign mpe_set = cmd.parity_error_response & (rx_poison_cpl | tx_poison_req);

  // Command and status next values; a new poison event wins over a clearing write
  always_comb begin
    cmd_next = cmd_reg;
    sts_next = sts_reg;
    if (wr_cmd) begin
      // Hardwired bits never take a write
      cmd_next = (cmd_reg & ~(wmask & ntfc_pkg::CMD_WR_MASK))
        | (cfg_req.data[15:0] & wmask & ntfc_pkg::CMD_WR_MASK);
      sts_next[ntfc_pkg::MPE_BIT] = sts_reg[ntfc_pkg::MPE_BIT] & ~w1c[ntfc_pkg::MPE_BIT];
    end
    if (mpe_set) begin
      sts_next[ntfc_pkg::MPE_BIT] = 1'b1;
    end
  end

  // Everything clears at reset so decoding and mastering start disabled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg <= ntfc_pkg::CMD_RST;
      sts_reg <= ntfc_pkg::STS_RST;
    end else begin
      cmd_reg <= cmd_next;
      sts_reg <= sts_next;
    end
  end

  // Read path: one cycle after the request, unmapped dwords read zero
  always_comb begin
    rvalid_next = cfg_req.valid & ~cfg_req.write;
    rdata_next = 32'h0000_0000;
    if (cfg_req.valid && !cfg_req.write) begin
      case (cfg_req.dw)
        ntfc_pkg::ID_DW: rdata_next = {ntfc_pkg::DEVICE_CODE_DEF, ntfc_pkg::VENDOR_CODE_DEF};
        ntfc_pkg::CMD_DW: begin
          rdata_next[15:0] = cmd_reg & ntfc_pkg::CMD_WR_MASK;
          rdata_next[31:16] = sts_reg
            | (16'(intx_status) << ntfc_pkg::INTS_BIT)
            | (16'h0001 << ntfc_pkg::CAPL_BIT);
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;
  // Pending interrupt is visible even when disabled from the pin
  assign intx_status = intx_req;

  ntfc_gate u_gate (
    .cmd(cmd),
    .rx_io_hit(rx_io_hit),
    .rx_mem_hit(rx_mem_hit),
    .rx_unsupported(rx_unsupported),
    .ip_req_in(ip_req_in),
    .msi_req_in(msi_req_in),
    .other_req_in(other_req_in),
    .ip_req_out(ip_req_out),
    .msi_req_out(msi_req_out),
    .other_req_out(other_req_out),
    .err_detect(err_detect),
    .dev_ctl_err_en(dev_ctl_err_en),
    .err_report(err_report),
    .intx_req(intx_req),
    .intx_out(intx_out)
  );

  // Checks
  a_id_read_value: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && cfg_req.dw == ntfc_pkg::ID_DW) |=> cfg_rdata[15:0] == ntfc_pkg::VENDOR_CODE_DEF)
    else $error("vendor code read wrong");
  a_dev_read_value: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && cfg_req.dw == ntfc_pkg::ID_DW) |=> cfg_rdata[31:16] == ntfc_pkg::DEVICE_CODE_DEF)
    else $error("device code read wrong");
  a_io_ur_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_io_hit && !cmd_reg[0]) |-> rx_unsupported) else $error("io access not refused");
  a_mem_ur_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_mem_hit && !cmd_reg[1]) |-> rx_unsupported) else $error("memory access not refused");
  a_bm_gate_out: assert property (@(posedge mclk) disable iff (!rst_b)
    ip_req_out |-> (cmd_reg[2] && ip_req_in)) else $error("request sent without mastering");
  a_msi_gate_out: assert property (@(posedge mclk) disable iff (!rst_b)
    msi_req_out |-> cmd_reg[2]) else $error("msi sent without mastering");
  a_other_pass_through: assert property (@(posedge mclk) disable iff (!rst_b)
    other_req_out == other_req_in) else $error("other request blocked");
  a_mpe_no_log: assert property (@(posedge mclk) disable iff (!rst_b)
    (!cmd_reg[6] && !sts_reg[8]) |=> !sts_reg[8]) else $error("parity logged while disabled");
  a_err_report_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    err_report |-> (err_detect && (cmd_reg[8] || dev_ctl_err_en))) else $error("error reported while disabled");
  a_intx_negate: assert property (@(posedge mclk) disable iff (!rst_b)
    cmd_reg[10] |-> !intx_out) else $error("intx not negated");
  a_ro_bits_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (cmd_reg & ~16'h0547) == 16'h0000) else $error("read-only command bit set");
  a_reset_cmd_zero: assert property (@(posedge mclk)
    $rose(rst_b) |-> cmd_reg == 16'h0000) else $error("command not cleared at reset");
  a_mpe_sets: assert property (@(posedge mclk) disable iff (!rst_b)
    (cmd_reg[6] && (rx_poison_cpl || tx_poison_req)) |=> sts_reg[8]) else $error("parity error not logged");
  a_be_keeps_low: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_cmd && !cfg_req.be[0]) |=> cmd_reg[7:0] == $past(cmd_reg[7:0])) else $error("masked byte written");

  // Enabled paths must pass traffic, so a gate stuck closed is caught too
  a_io_decode_open: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_io_hit && !rx_mem_hit && cmd_reg[ntfc_pkg::IO_EN_BIT]) |-> !rx_unsupported)
    else $error("io access refused while enabled");
  a_mem_decode_open: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_mem_hit && !rx_io_hit && cmd_reg[ntfc_pkg::MEM_EN_BIT]) |-> !rx_unsupported)
    else $error("memory access refused while enabled");
  a_ip_req_pass: assert property (@(posedge mclk) disable iff (!rst_b)
    (ip_req_in && cmd_reg[ntfc_pkg::BM_EN_BIT]) |-> ip_req_out)
    else $error("request held with mastering on");
  a_msi_req_pass: assert property (@(posedge mclk) disable iff (!rst_b)
    (msi_req_in && cmd_reg[ntfc_pkg::BM_EN_BIT]) |-> msi_req_out)
    else $error("msi held with mastering on");
  a_err_report_pass: assert property (@(posedge mclk) disable iff (!rst_b)
    (err_detect && (cmd_reg[ntfc_pkg::SERR_EN_BIT] || dev_ctl_err_en)) |-> err_report)
    else $error("error report lost while enabled");
  a_intx_pass: assert property (@(posedge mclk) disable iff (!rst_b)
    (intx_req && !cmd_reg[ntfc_pkg::INTX_DIS_BIT]) |-> intx_out)
    else $error("intx lost while allowed");
  a_intx_state: assert property (@(posedge mclk) disable iff (!rst_b)
    intx_status == intx_req)
    else $error("resolved interrupt state wrong");

  // Read answer stands for one cycle only, and idle read data is zero
  a_rvalid_on_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write) |=> cfg_rvalid)
    else $error("read not answered");
  a_rvalid_no_read: assert property (@(posedge mclk) disable iff (!rst_b)
    !(cfg_req.valid && !cfg_req.write) |=> !cfg_rvalid)
    else $error("answer without a read");
  a_rdata_idle_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    !cfg_rvalid |-> cfg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  a_ro_read_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && cfg_req.dw == ntfc_pkg::CMD_DW) |=> (cfg_rdata[15:0] & ~ntfc_pkg::CMD_WR_MASK) == 16'h0000)
    else $error("read-only command bit read as one");
  a_cmd_write_lands: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_cmd && cfg_req.be[0]) |=> cmd_reg[7:0] == ($past(cfg_req.data[7:0]) & ntfc_pkg::CMD_WR_MASK[7:0]))
    else $error("enabled byte not written");

  // Parity status is sticky until a one is written into its own byte lane
  a_mpe_holds: assert property (@(posedge mclk) disable iff (!rst_b)
    (sts_reg[ntfc_pkg::MPE_BIT] && !(wr_cmd && w1c[ntfc_pkg::MPE_BIT])) |=> sts_reg[ntfc_pkg::MPE_BIT])
    else $error("parity status lost");
  a_mpe_clear_w1c: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_cmd && w1c[ntfc_pkg::MPE_BIT] && !mpe_set) |=> !sts_reg[ntfc_pkg::MPE_BIT])
    else $error("parity status not cleared");
endmodule : ntfc_top

// ### ntfc_host_model.sv
// Host side model: issues configuration reads and writes toward the function
`timescale 1ns/1ps
module ntfc_host_model (
  // Clock
  input wire logic mclk,
  // Configuration access
  output ntfc_pkg::ntfc_cfg_req_s cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  logic [31:0] rd_data;
  logic rd_ok;
  initial cfg_req = '0;
  // One request per call; idle data is scrambled so stale values never look valid
  task automatic xfer(input logic wr, input logic [9:0] dw, input logic [3:0] be, input logic [31:0] d);
    int n;
    @(posedge mclk);
    cfg_req <= '{1'b1, wr, dw, be, d};
    @(posedge mclk);
    cfg_req.valid <= 1'b0;
    cfg_req.data <= ~d;
    rd_ok = 1'b0;
    if (!wr) begin
      n = 0;
      #1;
      while (cfg_rvalid !== 1'b1 && n < 4) begin
        @(posedge mclk);
        #1;
        n++;
      end
      rd_ok = (cfg_rvalid === 1'b1);
      rd_data = cfg_rdata;
    end
  endtask : xfer
endmodule : ntfc_host_model

// ### test_ntfc_top.sv
// Self-checking bench for the function command block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ntfc_top;
  logic mclk, rst_b, cfg_rvalid, rx_io_hit, rx_mem_hit, rx_unsupported, ip_req_in, msi_req_in, other_req_in;
  logic ip_req_out, msi_req_out, other_req_out, rx_poison_cpl, tx_poison_req, err_detect, dev_ctl_err_en;
  logic err_report, intx_req, intx_out, intx_status;
  logic [31:0] cfg_rdata;
  ntfc_pkg::ntfc_cfg_req_s cfg_req;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  ntfc_top dut (.mclk, .rst_b, .cfg_req, .cfg_rdata, .cfg_rvalid, .rx_io_hit, .rx_mem_hit, .rx_unsupported,
    .ip_req_in, .msi_req_in, .other_req_in, .ip_req_out, .msi_req_out, .other_req_out, .rx_poison_cpl,
    .tx_poison_req, .err_detect, .dev_ctl_err_en, .err_report, .intx_req, .intx_out, .intx_status);
  ntfc_host_model host (.mclk, .cfg_req, .cfg_rdata, .cfg_rvalid);

  // Clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Hang guard, far above the roughly 70 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic rd(input logic [9:0] dw, input logic [31:0] exp);
    host.xfer(1'b0, dw, 4'hf, 32'h0);
    `CHK({host.rd_ok, host.rd_data}, {1'b1, exp})
  endtask : rd

  task automatic wr(input logic [9:0] dw, input logic [3:0] be, input logic [31:0] d);
    host.xfer(1'b1, dw, be, d);
  endtask : wr

  // Gated outputs are combinational, so look a step after the edge
  task automatic outs(input logic [5:0] exp);
    @(posedge mclk);
    #1;
    `CHK({rx_unsupported, ip_req_out, msi_req_out, other_req_out, err_report, intx_out}, exp)
  endtask : outs

  task automatic poison(input logic tx);
    @(posedge mclk);
    if (tx) tx_poison_req <= 1'b1;
    else rx_poison_cpl <= 1'b1;
    @(posedge mclk);
    tx_poison_req <= 1'b0;
    rx_poison_cpl <= 1'b0;
  endtask : poison

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {rx_io_hit, rx_mem_hit, ip_req_in, msi_req_in, other_req_in, err_detect} = 6'h3f;
    {rx_poison_cpl, tx_poison_req, dev_ctl_err_en, intx_req} = 4'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(ntfc_pkg::ID_DW, {ntfc_pkg::DEVICE_CODE_DEF, ntfc_pkg::VENDOR_CODE_DEF});
    rd(ntfc_pkg::CMD_DW, 32'h0010_0000);
    outs(6'b100100);
    `CHK(intx_status, 1'b0)
    wr(ntfc_pkg::ID_DW, 4'hf, 32'hffff_ffff);
    rd(ntfc_pkg::ID_DW, {ntfc_pkg::DEVICE_CODE_DEF, ntfc_pkg::VENDOR_CODE_DEF});
    rd(10'h002, 32'h0);
    // All ones into command: only the writable bits may stick
    wr(ntfc_pkg::CMD_DW, 4'h3, 32'h0000_ffff);
    rd(ntfc_pkg::CMD_DW, {16'h0010, ntfc_pkg::CMD_WR_MASK});
    @(posedge mclk) intx_req <= 1'b1;
    outs(6'b011110);
    `CHK(intx_status, 1'b1)
    rd(ntfc_pkg::CMD_DW, 32'h0018_0547);
    // Upper command byte only
    wr(ntfc_pkg::CMD_DW, 4'h2, 32'h0);
    rd(ntfc_pkg::CMD_DW, 32'h0018_0047);
    outs(6'b011101);
    @(posedge mclk) dev_ctl_err_en <= 1'b1;
    outs(6'b011111);
    // Poison logging with parity response on; status bit 8 sits in byte lane three
    poison(1'b0);
    rd(ntfc_pkg::CMD_DW, 32'h0118_0047);
    wr(ntfc_pkg::CMD_DW, 4'h8, 32'h0100_0000);
    rd(ntfc_pkg::CMD_DW, 32'h0018_0047);
    poison(1'b1);
    rd(ntfc_pkg::CMD_DW, 32'h0118_0047);
    wr(ntfc_pkg::CMD_DW, 4'h8, 32'h0100_0000);
    // Parity response off: neither event is logged
    wr(ntfc_pkg::CMD_DW, 4'h1, 32'h0);
    poison(1'b0);
    poison(1'b1);
    rd(ntfc_pkg::CMD_DW, 32'h0018_0000);
    outs(6'b100111);
    // One decode space at a time, so each enable is seen on its own
    wr(ntfc_pkg::CMD_DW, 4'h1, 32'h0000_0002);
    @(posedge mclk) rx_io_hit <= 1'b0;
    outs(6'b000111);
    @(posedge mclk) {rx_io_hit, rx_mem_hit} <= 2'b10;
    outs(6'b100111);
    wr(ntfc_pkg::CMD_DW, 4'h1, 32'h0000_0001);
    outs(6'b000111);
    @(posedge mclk) {rx_io_hit, rx_mem_hit} <= 2'b01;
    outs(6'b100111);
    // Reset in mid-run clears a populated command
    wr(ntfc_pkg::CMD_DW, 4'h3, 32'h0000_0547);
    rd(ntfc_pkg::CMD_DW, 32'h0018_0547);
    @(posedge mclk) rst_b <= 1'b0;
    @(posedge mclk) rst_b <= 1'b1;
    rd(ntfc_pkg::CMD_DW, 32'h0018_0000);
    end_of_test();
  end
endmodule : test_ntfc_top
